// file: uorc_role_ctrl.sv
// Role selection, line termination control and token direction mapping.
// Assumes an AXI4-Lite master and a level from the VBUS session comparator.
`timescale 1ns/1ps
module uorc_role_ctrl
  import uorc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [UORC_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [UORC_DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [UORC_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [UORC_DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic session_valid_threshold,
  input wire logic tok_in_valid,
  output logic tok_in_ready,
  input wire logic [UORC_PID_W-1:0] tok_in_pid,
  input wire logic [UORC_EP_W-1:0] tok_in_endpoint,
  input wire logic [UORC_TYPE_W-1:0] tok_in_type,
  output logic tok_out_valid,
  input wire logic tok_out_ready,
  output logic [UORC_PID_W-1:0] tok_out_pid,
  output logic [UORC_EP_W-1:0] tok_out_endpoint,
  output logic [UORC_TYPE_W-1:0] tok_out_type,
  output logic tok_out_is_rx,
  output logic dplus_pullup_en,
  output logic dplus_pulldown_en,
  output logic dminus_pulldown_en,
  output logic host_mode,
  output logic low_speed_en
);
  localparam int unsigned TOK_W = UORC_PID_W + UORC_EP_W + UORC_TYPE_W + 2;

  function automatic logic is_token(input logic [UORC_PID_W-1:0] pid);
    is_token = (pid == UORC_PID_OUT) | (pid == UORC_PID_IN) | (pid == UORC_PID_SETUP);
  endfunction

  function automatic logic pid_is_rx(input logic [UORC_PID_W-1:0] pid, input logic host);
    pid_is_rx = host ? (pid == UORC_PID_IN) : (pid != UORC_PID_IN);
  endfunction

  logic [7:0] module_control_reg;
  logic [7:0] role_control_reg;
  logic module_power_bit;
  logic [UORC_NUM_EP-1:0] pending;
  logic bad_token;
  logic aw_held;
  logic w_held;
  logic [UORC_ADDR_W-1:0] aw_addr;
  logic [UORC_DATA_W-1:0] w_data;
  logic [3:0] w_strb;

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write side: address and data latched independently
  wire aw_take = s_axi_awvalid & s_axi_awready;
  wire w_take = s_axi_wvalid & s_axi_wready;
  wire wr_fire = aw_held & w_held & ~s_axi_bvalid;
  wire wr_ctrl = wr_fire & (aw_addr == UORC_OFS_CTRL) & w_strb[0];
  wire wr_role = wr_fire & (aw_addr == UORC_OFS_ROLE) & w_strb[0];
  wire wr_power = wr_fire & (aw_addr == UORC_OFS_POWER) & w_strb[0];
  wire wr_status = wr_fire & (aw_addr == UORC_OFS_STATUS) & w_strb[1];
  wire wr_pend = wr_fire & (aw_addr == UORC_OFS_PEND) & (w_strb[1:0] == 2'b11);
  wire wr_mapped = (aw_addr == UORC_OFS_CTRL) | (aw_addr == UORC_OFS_ROLE) |
                   (aw_addr == UORC_OFS_POWER) | (aw_addr == UORC_OFS_STATUS) |
                   (aw_addr == UORC_OFS_PEND);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= UORC_RESP_OKAY;
      aw_addr <= '0;
      w_data <= '0;
      w_strb <= '0;
    end else begin
      if (aw_take) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (w_take) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_mapped ? UORC_RESP_OKAY : UORC_RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control registers; role may change at any write, nothing is reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      module_control_reg <= UORC_CTRL_RESET;
      role_control_reg <= UORC_ROLE_RESET;
      module_power_bit <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        module_control_reg <= w_data[7:0];
      end
      if (wr_role) begin
        role_control_reg <= w_data[7:0];
      end
      if (wr_power) begin
        module_power_bit <= w_data[UORC_POWER_ON];
      end
    end
  end

  wire module_enable_bit = module_control_reg[UORC_CTRL_ENABLE];
  wire host_role_enable = module_control_reg[UORC_CTRL_HOST];
  wire low_speed_req = module_control_reg[UORC_CTRL_LOW_SPEED];
  wire dual_role_override_enable = role_control_reg[UORC_ROLE_OVERRIDE];
  wire dplus_pullup_ctl = role_control_reg[UORC_ROLE_DP_PU];
  wire dplus_pulldown_ctl = role_control_reg[UORC_ROLE_DP_PD];
  wire dminus_pulldown_ctl = role_control_reg[UORC_ROLE_DM_PD];

  ////////////////////////////////////////////////////////////////////////////
  // Line terminations
  wire pullup_sw = dual_role_override_enable ? dplus_pullup_ctl
                   : (module_enable_bit & module_power_bit);
  // Comparator has the last word so back drive is avoided without firmware
  wire next_pullup = pullup_sw & session_valid_threshold;
  wire next_dp_pd = dual_role_override_enable ? dplus_pulldown_ctl
                    : host_role_enable;
  wire next_dm_pd = dual_role_override_enable ? dminus_pulldown_ctl
                    : host_role_enable;
  // Low speed is refused in peripheral role
  wire next_low_speed = low_speed_req & host_role_enable;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dplus_pullup_en <= 1'b0;
      dplus_pulldown_en <= 1'b0;
      dminus_pulldown_en <= 1'b0;
      host_mode <= 1'b0;
      low_speed_en <= 1'b0;
    end else begin
      dplus_pullup_en <= next_pullup;
      dplus_pulldown_en <= next_dp_pd;
      dminus_pulldown_en <= next_dm_pd;
      host_mode <= host_role_enable;
      low_speed_en <= next_low_speed;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Token path, shared by both roles
  logic buf_out_host;
  logic buf_in_ready;
  wire in_is_token = is_token(tok_in_pid);
  wire in_take = tok_in_valid & buf_in_ready;
  wire in_rx = pid_is_rx(tok_in_pid, host_role_enable);
  wire [TOK_W-1:0] in_word = {host_role_enable, in_rx, tok_in_type,
                              tok_in_endpoint, tok_in_pid};
  assign tok_in_ready = buf_in_ready;

  uorc_skid_buf #(
    .WIDTH(TOK_W)
  ) u_tok_buf (
    .aclk(aclk),
    .aresetn(aresetn),
    .in_valid(tok_in_valid & in_is_token),
    .in_ready(buf_in_ready),
    .in_data(in_word),
    .out_valid(tok_out_valid),
    .out_ready(tok_out_ready),
    .out_data({buf_out_host, tok_out_is_rx, tok_out_type, tok_out_endpoint, tok_out_pid})
  );

  wire out_done = tok_out_valid & tok_out_ready;
  wire [UORC_NUM_EP-1:0] done_mask = out_done ? (16'h0001 << tok_out_endpoint) : 16'h0000;
  wire [UORC_NUM_EP-1:0] arm_mask = wr_pend ? w_data[UORC_NUM_EP-1:0] : 16'h0000;
  wire next_bad_clr = wr_status & w_data[UORC_ST_BAD_TOKEN];

  // Arming wins over a completion in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pending <= '0;
      bad_token <= 1'b0;
    end else begin
      pending <= (pending & ~done_mask) | arm_mask;
      bad_token <= (bad_token & ~next_bad_clr) | (in_take & ~in_is_token);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read side
  wire [UORC_DATA_W-1:0] status_word = {23'h00_0000, bad_token, 2'b00, low_speed_en,
                                        host_mode, dminus_pulldown_en, dplus_pulldown_en,
                                        dplus_pullup_en, session_valid_threshold};
  wire rd_take = s_axi_arvalid & s_axi_arready;
  wire rd_hit_ctrl = s_axi_araddr == UORC_OFS_CTRL;
  wire rd_hit_role = s_axi_araddr == UORC_OFS_ROLE;
  wire rd_hit_power = s_axi_araddr == UORC_OFS_POWER;
  wire rd_hit_status = s_axi_araddr == UORC_OFS_STATUS;
  wire rd_hit_pend = s_axi_araddr == UORC_OFS_PEND;
  wire rd_mapped = rd_hit_ctrl | rd_hit_role | rd_hit_power | rd_hit_status | rd_hit_pend;
  wire [UORC_DATA_W-1:0] rd_word =
    rd_hit_ctrl ? {24'h00_0000, module_control_reg} :
    rd_hit_role ? {24'h00_0000, role_control_reg} :
    rd_hit_power ? {31'h0000_0000, module_power_bit} :
    rd_hit_status ? status_word :
    rd_hit_pend ? {16'h0000, pending} : 32'h0000_0000;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= UORC_RESP_OKAY;
    end else if (rd_take) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= rd_mapped ? UORC_RESP_OKAY : UORC_RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  pullup_direct_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !dual_role_override_enable && session_valid_threshold |=>
    dplus_pullup_en == ($past(module_enable_bit) && $past(module_power_bit)))
    else $error("pull-up does not follow enable and power");

  pullup_override_a: assert property (@(posedge aclk) disable iff (!aresetn)
    dual_role_override_enable && session_valid_threshold |=>
    dplus_pullup_en == $past(dplus_pullup_ctl))
    else $error("pull-up does not follow override bit");

  vbus_drop_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !session_valid_threshold |=> !dplus_pullup_en)
    else $error("pull-up on below session valid");

  pulldown_host_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !dual_role_override_enable && host_role_enable |=> dplus_pulldown_en && dminus_pulldown_en)
    else $error("pull-downs missing in host role");

  pulldown_override_a: assert property (@(posedge aclk) disable iff (!aresetn)
    dual_role_override_enable |=> dplus_pulldown_en == $past(dplus_pulldown_ctl) &&
    dminus_pulldown_en == $past(dminus_pulldown_ctl))
    else $error("pull-downs do not follow override bits");

  bits_ignored_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !dual_role_override_enable && !host_role_enable |=> !dplus_pulldown_en && !dminus_pulldown_en)
    else $error("pull-down on without host or override");

  low_speed_host_a: assert property (@(posedge aclk) disable iff (!aresetn)
    low_speed_en |-> host_mode)
    else $error("low speed outside host role");

  token_direction_a: assert property (@(posedge aclk) disable iff (!aresetn)
    tok_out_valid |-> tok_out_is_rx == (buf_out_host ? (tok_out_pid == UORC_PID_IN)
                                                     : (tok_out_pid != UORC_PID_IN)))
    else $error("token direction wrong for role");

  pending_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
    out_done && !arm_mask[tok_out_endpoint] |=> !pending[$past(tok_out_endpoint)])
    else $error("pending bit not cleared on completion");

  token_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    tok_out_valid && !tok_out_ready |=> tok_out_valid && $stable(tok_out_pid) &&
    $stable(tok_out_endpoint))
    else $error("token dropped under stall");

  pullup_on_c: cover property (@(posedge aclk) disable iff (!aresetn) dplus_pullup_en);
  host_pd_c: cover property (@(posedge aclk) disable iff (!aresetn)
    host_mode && dplus_pulldown_en && dminus_pulldown_en);
  override_c: cover property (@(posedge aclk) disable iff (!aresetn)
    dual_role_override_enable ##1 dplus_pullup_en);
  token_stall_c: cover property (@(posedge aclk) disable iff (!aresetn)
    tok_out_valid && !tok_out_ready ##1 out_done);
endmodule // uorc_role_ctrl

// file: uorc_pkg.sv
// Shared constants for the role and bus termination controller.
// Assumes an AXI4-Lite master with 32-bit data and word-aligned registers.
package uorc_pkg;
  localparam int unsigned UORC_ADDR_W = 8;
  localparam int unsigned UORC_DATA_W = 32;
  localparam int unsigned UORC_EP_W = 4;
  localparam int unsigned UORC_NUM_EP = 16;
  localparam int unsigned UORC_PID_W = 4;
  localparam int unsigned UORC_TYPE_W = 2;

  localparam logic [7:0] UORC_OFS_CTRL = 8'h00;
  localparam logic [7:0] UORC_OFS_ROLE = 8'h04;
  localparam logic [7:0] UORC_OFS_POWER = 8'h08;
  localparam logic [7:0] UORC_OFS_STATUS = 8'h0c;
  localparam logic [7:0] UORC_OFS_PEND = 8'h10;

  // Module control fields
  localparam int unsigned UORC_CTRL_ENABLE = 0;
  localparam int unsigned UORC_CTRL_LOW_SPEED = 1;
  localparam int unsigned UORC_CTRL_HOST = 3;
  // Role control fields
  localparam int unsigned UORC_ROLE_OVERRIDE = 2;
  localparam int unsigned UORC_ROLE_DM_PD = 4;
  localparam int unsigned UORC_ROLE_DP_PD = 5;
  localparam int unsigned UORC_ROLE_DP_PU = 7;
  // Power field
  localparam int unsigned UORC_POWER_ON = 0;
  // Status fields
  localparam int unsigned UORC_ST_SESSION = 0;
  localparam int unsigned UORC_ST_PULLUP = 1;
  localparam int unsigned UORC_ST_DP_PD = 2;
  localparam int unsigned UORC_ST_DM_PD = 3;
  localparam int unsigned UORC_ST_HOST = 4;
  localparam int unsigned UORC_ST_LOW_SPEED = 5;
  localparam int unsigned UORC_ST_BAD_TOKEN = 8;

  localparam logic [7:0] UORC_CTRL_RESET = 8'h00;
  localparam logic [7:0] UORC_ROLE_RESET = 8'h00;

  localparam logic [3:0] UORC_PID_OUT = 4'h1;
  localparam logic [3:0] UORC_PID_IN = 4'h9;
  localparam logic [3:0] UORC_PID_SETUP = 4'hd;

  localparam logic [1:0] UORC_RESP_OKAY = 2'h0;
  localparam logic [1:0] UORC_RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    UORC_XFER_CONTROL,
    UORC_XFER_ISOCHRONOUS,
    UORC_XFER_BULK,
    UORC_XFER_INTERRUPT
  } uorc_xfer_t;
endpackage

// file: uorc_skid_buf.sv
// Two-entry valid/ready buffer with registered outputs.
// Assumes a single clock and a synchronous active-low reset.
`timescale 1ns/1ps
module uorc_skid_buf #(
  parameter int unsigned WIDTH = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  logic [WIDTH-1:0] skid_data;
  wire out_free = out_ready | ~out_valid;
  wire in_take = in_valid & in_ready;

  // in_ready is the inverse of skid occupancy, kept as its own flop
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      out_valid <= 1'b0;
      in_ready <= 1'b1;
    end else if (out_free) begin
      out_valid <= ~in_ready | in_valid;
      in_ready <= 1'b1;
    end else if (in_take) begin
      in_ready <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (out_free) begin
      out_data <= in_ready ? in_data : skid_data;
    end
    if (!out_free && in_take) begin
      skid_data <= in_data;
    end
  end
endmodule // uorc_skid_buf

// file: uorc_usb_peer.sv
// Far-side model: token source into the controller and token sink at its output.
// Assumes one clock and that the bench drives sink_stall at rising edges.
`timescale 1ns/1ps
module uorc_usb_peer
  import uorc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic sink_stall,
  output logic tok_in_valid,
  input wire logic tok_in_ready,
  output logic [UORC_PID_W-1:0] tok_in_pid,
  output logic [UORC_EP_W-1:0] tok_in_endpoint,
  output logic [UORC_TYPE_W-1:0] tok_in_type,
  input wire logic tok_out_valid,
  output logic tok_out_ready,
  input wire logic [UORC_PID_W-1:0] tok_out_pid,
  input wire logic [UORC_EP_W-1:0] tok_out_endpoint,
  input wire logic [UORC_TYPE_W-1:0] tok_out_type,
  input wire logic tok_out_is_rx
);
  logic [10:0] got[$];
  logic timed_out;
  initial begin
    tok_in_valid = 1'b0;
    tok_in_pid = 4'h0;
    tok_in_endpoint = 4'h0;
    tok_in_type = 2'h0;
    timed_out = 1'b0;
  end
  assign tok_out_ready = !sink_stall;
  ////////////////////////////////////////////////////////////////////////////////
  // Hold the token until taken; released lines show the inverse, not a stale copy
  task automatic send(input logic [3:0] pid, input logic [3:0] ep, input logic [1:0] ty);
    int n;
    n = 0;
    tok_in_valid <= 1'b1;
    tok_in_pid <= pid;
    tok_in_endpoint <= ep;
    tok_in_type <= ty;
    do begin
      @(posedge aclk);
      n++;
    end while (!tok_in_ready && n < 200);
    if (n >= 200) timed_out = 1'b1;
    tok_in_valid <= 1'b0;
    tok_in_pid <= ~pid;
    tok_in_endpoint <= ~ep;
    tok_in_type <= ~ty;
  endtask
  always @(posedge aclk) begin
    if (aresetn && tok_out_valid && tok_out_ready) begin
      got.push_back({tok_out_pid, tok_out_endpoint, tok_out_type, tok_out_is_rx});
    end
  end
endmodule // uorc_usb_peer

// file: uorc_role_ctrl_tb.sv
// Self-checking bench: AXI4-Lite register tasks plus token traffic via the peer.
// Assumes the controller answers AXI within a few cycles; every wait is bounded.
`timescale 1ns/1ps
module uorc_role_ctrl_tb;
  import uorc_pkg::*;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, session, stall;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, resp;
  logic ti_v, ti_r, to_v, to_r, to_rx, pu, dpd, dmd, hm, ls;
  logic [3:0] ti_pid, ti_ep, to_pid, to_ep;
  logic [1:0] ti_ty, to_ty;
  logic [3:0] pids[3];
  int fail_count, total_checks;
  uorc_role_ctrl DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .session_valid_threshold(session), .tok_in_valid(ti_v),
    .tok_in_ready(ti_r), .tok_in_pid(ti_pid), .tok_in_endpoint(ti_ep), .tok_in_type(ti_ty),
    .tok_out_valid(to_v), .tok_out_ready(to_r), .tok_out_pid(to_pid),
    .tok_out_endpoint(to_ep), .tok_out_type(to_ty), .tok_out_is_rx(to_rx),
    .dplus_pullup_en(pu), .dplus_pulldown_en(dpd), .dminus_pulldown_en(dmd),
    .host_mode(hm), .low_speed_en(ls));
  uorc_usb_peer PEER (.aclk(aclk), .aresetn(aresetn), .sink_stall(stall), .tok_in_valid(ti_v),
    .tok_in_ready(ti_r), .tok_in_pid(ti_pid), .tok_in_endpoint(ti_ep), .tok_in_type(ti_ty),
    .tok_out_valid(to_v), .tok_out_ready(to_r), .tok_out_pid(to_pid),
    .tok_out_endpoint(to_ep), .tok_out_type(to_ty), .tok_out_is_rx(to_rx));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    if (fail_count == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
      fail_count++;
    end
  endtask
  task automatic timeout(input int n);
    if (n >= 100) begin
      $display("Error at %0t: bus wait timed out", $time);
      fail_count++;
      stop_test();
    end
  endtask
  // Address and data offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'h1);
    logic aw_ok, w_ok;
    int n;
    aw_ok = 0;
    w_ok = 0;
    n = 0;
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (!aw_ok && awready) begin aw_ok = 1; awvalid <= 1'b0; end
      if (!w_ok && wready) begin w_ok = 1; wvalid <= 1'b0; end
    end while (!(aw_ok && w_ok && bvalid) && n < 100);
    timeout(n);
    resp = bresp;
  endtask
  task automatic rd_reg(input logic [7:0] a);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (arready) arvalid <= 1'b0;
    end while (!rvalid && n < 100);
    timeout(n);
    rd = rdata;
    resp = rresp;
  endtask
  // Terminations settle one cycle after the register or the session level moves
  task automatic term(input logic [4:0] exp, input string what);
    repeat (3) @(posedge aclk);
    check({27'h0, pu, dpd, dmd, hm, ls}, {27'h0, exp}, what);
  endtask
  task automatic tok(input logic [3:0] p, input logic [3:0] e, input logic [1:0] t,
      input logic h);
    logic rx;
    rx = h ? (p == UORC_PID_IN) : (p == UORC_PID_OUT || p == UORC_PID_SETUP);
    PEER.send(p, e, t);
    repeat (3) @(posedge aclk);
    check(32'(PEER.got.size()), 32'h1, "token count");
    if (PEER.got.size() > 0) check(32'(PEER.got.pop_front()), {21'h0, p, e, t, rx}, "token");
  endtask
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, stall} = '0;
    {awaddr, araddr, wdata, wstrb} = '0;
    session = 1'b0;
    fail_count = 0;
    total_checks = 0;
    pids = '{UORC_PID_OUT, UORC_PID_IN, UORC_PID_SETUP};
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    check({27'h0, pu, dpd, dmd, hm, ls}, 32'h0, "reset terminations");
    rd_reg(UORC_OFS_CTRL);
    check(rd, 32'h0, "ctrl reset");
    rd_reg(UORC_OFS_ROLE);
    check(rd, 32'h0, "role reset");
    rd_reg(8'h20);
    check(rd, 32'h0, "unmapped read data");
    check(32'(resp), 32'(UORC_RESP_SLVERR), "unmapped read");
    wr(8'h24, 32'h0000_0001);
    check(32'(resp), 32'(UORC_RESP_SLVERR), "unmapped write");
    // Firmware waits for VBUS before enabling the pull-up
    session <= 1'b1;
    wr(UORC_OFS_POWER, 32'h0000_0001);
    wr(UORC_OFS_CTRL, 32'h0000_0001);
    term(5'b10000, "pullup on");
    rd_reg(UORC_OFS_STATUS);
    check(rd & 32'h0000_003f, 32'h0000_0003, "status");
    check(32'(resp), 32'(UORC_RESP_OKAY), "read okay");
    wr(UORC_OFS_POWER, 32'h0000_0000);
    term(5'b00000, "pullup needs power");
    wr(UORC_OFS_POWER, 32'h0000_0001);
    session <= 1'b0;
    term(5'b00000, "pullup drop on low vbus");
    session <= 1'b1;
    wr(UORC_OFS_ROLE, 32'h0000_00b0);
    term(5'b10000, "override bits ignored");
    wr(UORC_OFS_CTRL, 32'h0000_0000);
    term(5'b00000, "override bits ignored off");
    for (int k = 0; k < 8; k++) begin
      wr(UORC_OFS_ROLE, 32'h0000_0004 | (32'(k[2]) << 7) | (32'(k[1]) << 5) | (32'(k[0]) << 4));
      term({k[2:0], 2'b00}, "override terminations");
    end
    session <= 1'b0;
    // Low VBUS drops only the pull-up; override pull-downs stay on
    term(5'b01100, "override pullup low vbus");
    session <= 1'b1;
    wr(UORC_OFS_ROLE, 32'h0000_0000);
    wr(UORC_OFS_CTRL, 32'h0000_0002);
    term(5'b00000, "low speed refused as peripheral");
    wr(UORC_OFS_CTRL, 32'h0000_000a);
    term(5'b01111, "host pulldowns and low speed");
    for (int h = 1; h >= 0; h--) begin
      wr(UORC_OFS_CTRL, h ? 32'h0000_0008 : 32'h0000_0001);
      for (int i = 0; i < 4; i++) tok(pids[i % 3], 4'(i * 5), 2'(i), h[0]);
    end
    wr(UORC_OFS_PEND, 32'h0000_ffff, 4'h3);
    check(32'(resp), 32'(UORC_RESP_OKAY), "write okay");
    rd_reg(UORC_OFS_PEND);
    check(rd, 32'h0000_ffff, "pending armed");
    tok(UORC_PID_IN, 4'h3, 2'h2, 1'b0);
    rd_reg(UORC_OFS_PEND);
    check(rd, 32'h0000_fff7, "pending cleared by token");
    PEER.send(4'h5, 4'h1, 2'h0);
    repeat (3) @(posedge aclk);
    check(32'(PEER.got.size()), 32'h0, "bad token dropped");
    rd_reg(UORC_OFS_STATUS);
    check(rd & 32'h0000_0100, 32'h0000_0100, "bad token flag");
    wr(UORC_OFS_STATUS, 32'h0000_0100, 4'h2);
    rd_reg(UORC_OFS_STATUS);
    check(rd & 32'h0000_0100, 32'h0, "bad token cleared");
    stall <= 1'b1;
    PEER.send(UORC_PID_OUT, 4'h7, 2'h3);
    // An edge between sends, so valid is never driven twice in one step
    @(posedge aclk);
    PEER.send(UORC_PID_SETUP, 4'h8, 2'h0);
    repeat (4) @(posedge aclk);
    check(32'(ti_r), 32'h0, "buffer full refuses");
    stall <= 1'b0;
    repeat (6) @(posedge aclk);
    check(32'(PEER.got.size()), 32'h2, "buffer drained whole");
    if (PEER.got.size() == 2) begin
      check(32'(PEER.got.pop_front()), {21'h0, UORC_PID_OUT, 4'h7, 2'h3, 1'b1},
        "stalled first token");
      check(32'(PEER.got.pop_front()), {21'h0, UORC_PID_SETUP, 4'h8, 2'h0, 1'b1},
        "stalled second token");
    end
    check(32'(ti_r), 32'h1, "buffer ready again");
    check(32'(PEER.timed_out), 32'h0, "token source wait");
    stop_test();
  end
  initial begin
    #200000;
    $display("Error at %0t: run limit reached", $time);
    fail_count++;
    stop_test();
  end
endmodule // uorc_role_ctrl_tb
